// ===== ldui_loop_model.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------
// Roadway loop and detection core stand-in
// ------------------------------------------------
module ldui_loop_model (
  input wire logic occupy,
  input wire logic [3:0] level_set,
  output logic vehicle_present,
  output logic call_in,
  output logic [3:0] strength
);
  // Plain presence: a vehicle over the loop calls at once
  always_comb begin
    vehicle_present = occupy;
    call_in = occupy;
    // Strength reads zero on a vacant loop, not the last value
    strength = occupy ? level_set : 4'h0;
  end
endmodule // ldui_loop_model

`default_nettype wire

// ===== ldui_pkg.sv
`default_nettype none

package ldui_pkg;

  // ----------------------------------------------------------------
  // Clock and base tick
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;      // System clock rate
  localparam int TICK_HZ = 1000;           // One tick per millisecond
  localparam int TICK_CYC = CLK_HZ / TICK_HZ;
  localparam int TICK_W = 16;              // Tick divider width

  // ----------------------------------------------------------------
  // Times in milliseconds, flash rates in hertz
  // ----------------------------------------------------------------
  localparam int MS_W = 13;                // Millisecond counter width
  localparam int SHOW_MS = 5000;           // Level display window
  localparam int FRAME_MS = 2000;          // Low supply flash period
  localparam int PWR_FLASH_MS = 100;       // Short power lamp flash
  localparam int FLASH2_HZ = 2;            // Delay timing flash rate
  localparam int FLASH4_HZ = 4;            // Extension flash rate
  localparam int HALF2_MS = 1000 / (2 * FLASH2_HZ);
  localparam int HALF4_MS = 1000 / (2 * FLASH4_HZ);
  localparam int SLOT_MS = 250;            // One flash or gap slot
  localparam int GRP_MS = 3000;            // Flash group incl. pause
  localparam int DIG_MS = 750;             // One frequency digit
  localparam int DIG_ON_MS = 500;          // Lit part of that digit
  localparam int FCODE_MS = 1000;          // F then code digit
  localparam int RETUNE_MS = 2000;         // Retune after big change
  localparam int HOLD_MS = 4000;           // Call kept over power loss

  // ----------------------------------------------------------------
  // Sensitivity, switches and faults
  // ----------------------------------------------------------------
  localparam logic [3:0] LVL_MAX = 4'h9;
  localparam logic [3:0] LVL_DEFAULT = 4'h4;
  localparam logic [1:0] FREQ_LOW = 2'h0;
  localparam logic [1:0] FREQ_MLOW = 2'h1;
  localparam logic [1:0] FREQ_MHIGH = 2'h2;
  localparam logic [1:0] FREQ_HIGH = 2'h3;
  localparam logic [1:0] FLT_NONE = 2'h0;
  localparam logic [1:0] FLT_OPEN = 2'h1;
  localparam logic [1:0] FLT_SHORT = 2'h2;
  localparam logic [1:0] FLT_CHANGE = 2'h3;

  // ----------------------------------------------------------------
  // Meter characters and register map
  // ----------------------------------------------------------------
  localparam logic [3:0] CH_D = 4'hA;
  localparam logic [3:0] CH_E = 4'hB;
  localparam logic [3:0] CH_F = 4'hC;
  localparam logic [3:0] CH_BLANK = 4'hF;
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam int CTRL_CLR_BIT = 4;         // Write 1: forget last fault

  typedef enum logic {LDUI_FREQ, LDUI_RUN} ldui_mode_t;

endpackage

`default_nettype wire

// ===== ldui_top.sv
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module ldui_top #(
  parameter int TICK_CYCLES = ldui_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic btn_up,
  input wire logic btn_down,
  input wire logic reset_btn,
  input wire logic sw9_on,
  input wire logic sw10_on,
  input wire logic vehicle_present,
  input wire logic call_in,
  input wire logic delay_active,
  input wire logic ext_active,
  input wire logic fault_open,
  input wire logic fault_short,
  input wire logic fault_change,
  input wire logic low_supply,
  input wire logic pwr_fail,
  input wire logic [3:0] strength,
  input wire logic [9:0] loop_freq_khz,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic lamp_power,
  output logic lamp_output,
  output logic lamp_fault,
  output logic [6:0] seg,
  output logic call_a,
  output logic [1:0] freq_sel,
  output logic [3:0] sens_level,
  output logic retune
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // Divider must fit its counter
  if (TICK_CYCLES < 1 || TICK_CYCLES >= (1 << ldui_pkg::TICK_W)) begin : g_chk
    $error("TICK_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ldui_pkg::ldui_mode_t mode;            // Frequency show or run
    logic [ldui_pkg::TICK_W-1:0] tick_cnt; // Millisecond divider
    logic [ldui_pkg::MS_W-1:0] frame_ms;   // 2 s frame position
    logic [ldui_pkg::MS_W-1:0] grp_ms;     // Flash group position
    logic [ldui_pkg::MS_W-1:0] show_ms;    // Level window left
    logic [ldui_pkg::MS_W-1:0] dig_ms;     // Time in current digit
    logic [1:0] dig_idx;                   // 0 hundreds .. 2 ones
    logic [3:0] level;                     // Sensitivity level
    logic [1:0] cur_fault;                 // Fault seen last cycle
    logic [1:0] last_fault;                // Remembered fault
    logic [ldui_pkg::MS_W-1:0] rt_ms;      // Retune delay left
    logic [ldui_pkg::MS_W-1:0] pf_ms;      // Power loss duration
    logic up_d;                            // Button history
    logic dn_d;
    logic rb_d;
    logic call_a;
    logic lamp_power;
    logic lamp_output;
    logic lamp_fault;
    logic [6:0] seg;
    logic [1:0] freq_sel;
    logic retune;
    logic [31:0] rdata;
    logic waitreq;
  } ldui_state_t;

  ldui_state_t st_reg;   // Registered state
  ldui_state_t st_next;  // Next state

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Seven segment pattern, gfedcba, active high
  function automatic logic [6:0] seg_of(input logic [3:0] c);
    case (c)
      4'h0: seg_of = 7'h3F;
      4'h1: seg_of = 7'h06;
      4'h2: seg_of = 7'h5B;
      4'h3: seg_of = 7'h4F;
      4'h4: seg_of = 7'h66;
      4'h5: seg_of = 7'h6D;
      4'h6: seg_of = 7'h7D;
      4'h7: seg_of = 7'h07;
      4'h8: seg_of = 7'h7F;
      4'h9: seg_of = 7'h6F;
      ldui_pkg::CH_D: seg_of = 7'h5E;
      ldui_pkg::CH_E: seg_of = 7'h79;
      ldui_pkg::CH_F: seg_of = 7'h71;
      default: seg_of = 7'h00;
    endcase
  endfunction

  // Lamp level inside an n-flash group; slots after 2n stay dark
  function automatic logic flash_on(input logic [1:0] n,
                                    input logic [ldui_pkg::MS_W-1:0] t);
    logic [ldui_pkg::MS_W-1:0] slot;
    slot = ldui_pkg::MS_W'(t / ldui_pkg::SLOT_MS);
    flash_on = (slot < ldui_pkg::MS_W'(2 * n)) && !slot[0];
  endfunction

  // Millisecond counter step with wrap
  function automatic logic [ldui_pkg::MS_W-1:0] ms_wrap(
      input logic [ldui_pkg::MS_W-1:0] t, input int len);
    ms_wrap = (t == ldui_pkg::MS_W'(len - 1)) ? '0 : t + 1'b1;
  endfunction

  // ----------------------------------------------------------------
  // Combinational decode of inputs
  // ----------------------------------------------------------------
  logic tick;            // One cycle per millisecond
  logic up_p;            // Press edges
  logic dn_p;
  logic rb_p;
  logic [1:0] fault_now; // Open wins over short wins over change
  logic [3:0] hund;      // Frequency digits
  logic [3:0] tens;
  logic [3:0] ones;
  logic bus_ack;         // Access completes this edge

  always_comb begin
    tick = (st_reg.tick_cnt == ldui_pkg::TICK_W'(TICK_CYCLES - 1));
    up_p = btn_up && !st_reg.up_d;
    dn_p = btn_down && !st_reg.dn_d;
    rb_p = reset_btn && !st_reg.rb_d;
    if (fault_open) begin
      fault_now = ldui_pkg::FLT_OPEN;
    end else if (fault_short) begin
      fault_now = ldui_pkg::FLT_SHORT;
    end else if (fault_change) begin
      fault_now = ldui_pkg::FLT_CHANGE;
    end else begin
      fault_now = ldui_pkg::FLT_NONE;
    end
    hund = 4'(loop_freq_khz / 10'd100);
    tens = 4'((loop_freq_khz / 10'd10) % 10'd10);
    ones = 4'(loop_freq_khz % 10'd10);
    bus_ack = (avs_read || avs_write) && !st_reg.waitreq;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] ch;
    ch = ldui_pkg::CH_BLANK;
    st_next = st_reg;
    st_next.retune = 1'b0;
    st_next.up_d = btn_up;
    st_next.dn_d = btn_down;
    st_next.rb_d = reset_btn;
    st_next.cur_fault = fault_now;
    st_next.tick_cnt = tick ? '0 : st_reg.tick_cnt + 1'b1;

    // Free running time bases
    if (tick) begin
      st_next.frame_ms = ms_wrap(st_reg.frame_ms, ldui_pkg::FRAME_MS);
      st_next.grp_ms = ms_wrap(st_reg.grp_ms, ldui_pkg::GRP_MS);
    end

    case ({sw9_on, sw10_on})
      2'b11: st_next.freq_sel = ldui_pkg::FREQ_LOW;
      2'b01: st_next.freq_sel = ldui_pkg::FREQ_MLOW;
      2'b10: st_next.freq_sel = ldui_pkg::FREQ_MHIGH;
      default: st_next.freq_sel = ldui_pkg::FREQ_HIGH;
    endcase

    // Level window countdown
    if (tick && st_reg.show_ms != '0) begin
      st_next.show_ms = st_reg.show_ms - 1'b1;
    end
    // buttons only while the loop is vacant
    if ((up_p || dn_p) && !vehicle_present) begin
      // first press just opens the window
      st_next.show_ms = ldui_pkg::MS_W'(ldui_pkg::SHOW_MS);
      if (st_reg.show_ms != '0) begin
        // step within window; clamp to 0..9
        if (up_p && !dn_p && st_reg.level < ldui_pkg::LVL_MAX) begin
          st_next.level = st_reg.level + 1'b1;
        end else if (dn_p && !up_p && st_reg.level != 4'h0) begin
          st_next.level = st_reg.level - 1'b1;
        end
      end
    end

    // reset button forgets the last fault; set below still wins
    if (rb_p) begin
      st_next.last_fault = ldui_pkg::FLT_NONE;
    end
    if (bus_ack && avs_write && avs_address == ldui_pkg::ADDR_CTRL) begin
      if (avs_writedata[ldui_pkg::CTRL_CLR_BIT]) begin
        st_next.last_fault = ldui_pkg::FLT_NONE;
      end
      // Software level write, clamped to the top level
      st_next.level = (avs_writedata[3:0] > ldui_pkg::LVL_MAX) ?
                      ldui_pkg::LVL_MAX : avs_writedata[3:0];
    end
    // remember the type of the latest fault
    if (fault_now != ldui_pkg::FLT_NONE) begin
      st_next.last_fault = fault_now;
    end

    // schedule a retune once a large change clears
    if (st_reg.cur_fault == ldui_pkg::FLT_CHANGE &&
        fault_now == ldui_pkg::FLT_NONE) begin
      st_next.rt_ms = ldui_pkg::MS_W'(ldui_pkg::RETUNE_MS);
    end else if (tick && st_reg.rt_ms != '0) begin
      st_next.rt_ms = st_reg.rt_ms - 1'b1;
      st_next.retune = (st_reg.rt_ms == ldui_pkg::MS_W'(1));
    end

    // reset button retunes and restarts the frequency display
    if (rb_p) begin
      st_next.retune = 1'b1;
      st_next.mode = ldui_pkg::LDUI_FREQ;
      st_next.dig_idx = 2'h0;
      st_next.dig_ms = '0;
    end else begin
      case (st_reg.mode)
        // kHz digits, most significant first, then on to run mode
        ldui_pkg::LDUI_FREQ: begin
          if (st_reg.dig_idx == 2'h0 && hund == 4'h0) begin
            st_next.dig_idx = 2'h1;  // Two digit frequency
          end else if (tick) begin
            st_next.dig_ms = ms_wrap(st_reg.dig_ms, ldui_pkg::DIG_MS);
            if (st_reg.dig_ms == ldui_pkg::MS_W'(ldui_pkg::DIG_MS - 1)) begin
              st_next.dig_idx = st_reg.dig_idx + 1'b1;
              if (st_reg.dig_idx == 2'h2) begin
                st_next.mode = ldui_pkg::LDUI_RUN;
              end
            end
          end
        end
        default: begin
        end
      endcase
    end

    // call kept through a short loss; forced by a failure
    if (pwr_fail) begin
      if (tick && st_reg.pf_ms != ldui_pkg::MS_W'(ldui_pkg::HOLD_MS)) begin
        st_next.pf_ms = st_reg.pf_ms + 1'b1;
      end
      if (st_reg.pf_ms == ldui_pkg::MS_W'(ldui_pkg::HOLD_MS)) begin
        st_next.call_a = 1'b0;
      end
    end else begin
      st_next.pf_ms = '0;
      st_next.call_a = call_in || (fault_now != ldui_pkg::FLT_NONE);
    end

    // Lamps and meter, highest priority first
    st_next.lamp_power = 1'b1;
    st_next.lamp_fault = flash_on(st_reg.last_fault, st_reg.grp_ms);
    st_next.lamp_output = call_in;
    if (low_supply) begin
      // only a short power blink every frame
      st_next.lamp_power =
        st_reg.frame_ms < ldui_pkg::MS_W'(ldui_pkg::PWR_FLASH_MS);
      st_next.lamp_output = 1'b0;
      st_next.lamp_fault = 1'b0;
      ch = ldui_pkg::CH_BLANK;
    end else if (st_reg.mode == ldui_pkg::LDUI_FREQ) begin
      if (st_reg.dig_ms < ldui_pkg::MS_W'(ldui_pkg::DIG_ON_MS)) begin
        case (st_reg.dig_idx)
          2'h0: ch = hund;
          2'h1: ch = tens;
          default: ch = ones;
        endcase
      end
    end else if (fault_now != ldui_pkg::FLT_NONE) begin
      // group pattern repeats with a long pause
      st_next.lamp_output = flash_on(fault_now, st_reg.grp_ms);
      st_next.lamp_fault = flash_on(fault_now, st_reg.grp_ms);
      // F shown, then the code number
      ch = (st_reg.frame_ms < ldui_pkg::MS_W'(ldui_pkg::FCODE_MS)) ?
           ldui_pkg::CH_F : {2'b00, fault_now};
    end else begin
      if (delay_active) begin
        st_next.lamp_output =
          ((st_reg.frame_ms / ldui_pkg::HALF2_MS) % 2) == 0;
      end else if (ext_active) begin
        st_next.lamp_output =
          ((st_reg.frame_ms / ldui_pkg::HALF4_MS) % 2) == 0;
      end
      // level shown while the window runs
      if (st_reg.show_ms != '0) begin
        ch = st_reg.level;
      end else if (delay_active) begin
        ch = ldui_pkg::CH_D;
      end else if (ext_active) begin
        ch = ldui_pkg::CH_E;
      end else if (call_in) begin
        // Strength clamped to 1..9 while a call stands
        ch = (strength == 4'h0) ? 4'h1 :
             (strength > ldui_pkg::LVL_MAX) ? ldui_pkg::LVL_MAX : strength;
      end else begin
        ch = 4'h0;
      end
    end
    st_next.seg = seg_of(ch);

    // Avalon slave: one wait cycle, then acknowledge
    st_next.waitreq = !((avs_read || avs_write) && st_reg.waitreq);
    if ((avs_read || avs_write) && st_reg.waitreq) begin
      case (avs_address)
        ldui_pkg::ADDR_STATUS: st_next.rdata = {21'h0, low_supply,
          fault_now, st_reg.last_fault, st_reg.mode, call_in, st_reg.level};
        ldui_pkg::ADDR_CTRL: st_next.rdata = {28'h0, st_reg.level};
        default: st_next.rdata = 32'h0;  // Unmapped reads as zero
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // power-up shows frequency at the default level
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.mode <= ldui_pkg::LDUI_FREQ;
      st_reg.level <= ldui_pkg::LVL_DEFAULT;
      st_reg.freq_sel <= ldui_pkg::FREQ_HIGH;
      st_reg.waitreq <= 1'b1;
      st_reg.lamp_power <= 1'b1;
      st_reg.retune <= 1'b1;  // Power-up retune
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata = st_reg.rdata;
  assign avs_waitrequest = st_reg.waitreq;
  assign lamp_power = st_reg.lamp_power;
  assign lamp_output = st_reg.lamp_output;
  assign lamp_fault = st_reg.lamp_fault;
  assign seg = st_reg.seg;
  assign call_a = st_reg.call_a;
  assign freq_sel = st_reg.freq_sel;
  assign sens_level = st_reg.level;
  assign retune = st_reg.retune;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_press_in_window;
    up_p && !dn_p && !vehicle_present && st_reg.show_ms != '0 &&
    st_reg.level < ldui_pkg::LVL_MAX && !(bus_ack && avs_write);
  endsequence

  sequence s_first_press;
    (up_p || dn_p) && !vehicle_present && st_reg.show_ms == '0 &&
    !(bus_ack && avs_write);
  endsequence

  a_level_in_range: assert property (@(posedge clk) disable iff (rst)
    sens_level <= ldui_pkg::LVL_MAX) else $error("level above nine");

  a_step_up_level: assert property (@(posedge clk) disable iff (rst)
    s_press_in_window |=> sens_level == $past(sens_level) + 4'h1)
    else $error("level did not step up");

  a_first_press_hold: assert property (@(posedge clk) disable iff (rst)
    s_first_press |=> $stable(sens_level) &&
      st_reg.show_ms == ldui_pkg::MS_W'(ldui_pkg::SHOW_MS))
    else $error("first press changed level");

  a_vehicle_blocks: assert property (@(posedge clk) disable iff (rst)
    vehicle_present && !(bus_ack && avs_write) |=> $stable(sens_level))
    else $error("level changed with vehicle");

  a_fault_forces_a: assert property (@(posedge clk) disable iff (rst)
    fault_now != ldui_pkg::FLT_NONE && !pwr_fail |=> call_a)
    else $error("output A not forced on failure");

  a_low_supply_off: assert property (@(posedge clk) disable iff (rst)
    low_supply |=> !lamp_output && !lamp_fault && seg == 7'h00)
    else $error("indicators lit on low supply");

  a_reset_retunes: assert property (@(posedge clk) disable iff (rst)
    rb_p |=> retune && st_reg.mode == ldui_pkg::LDUI_FREQ)
    else $error("reset button did not retune");

  a_fault_memory: assert property (@(posedge clk) disable iff (rst)
    fault_now != ldui_pkg::FLT_NONE ##1 fault_now == ldui_pkg::FLT_NONE
    |-> st_reg.last_fault == $past(fault_now))
    else $error("last fault not remembered");

  a_call_held: assert property (@(posedge clk) disable iff (rst)
    pwr_fail && call_a &&
    st_reg.pf_ms < ldui_pkg::MS_W'(ldui_pkg::HOLD_MS) |=> call_a)
    else $error("call dropped during short loss");

  a_freq_map: assert property (@(posedge clk) disable iff (rst)
    sw9_on && sw10_on |=> freq_sel == ldui_pkg::FREQ_LOW)
    else $error("low frequency not selected");

endmodule // ldui_top

`default_nettype wire

// ===== ldui_top_tb.sv
`timescale 1ns/100ps
`default_nettype none

module ldui_top_tb;
  // ------------------------------------------------
  // Signals
  // ------------------------------------------------
  localparam int TC = 4; // Clocks per ms, short for simulation
  localparam logic [6:0] SG [0:12] = '{7'h3F, 7'h06, 7'h5B, 7'h4F,
    7'h66, 7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F, 7'h5E, 7'h79, 7'h71};
  typedef struct packed {
    logic s9;
    logic s10;
    logic occ;
    logic [3:0] str;
    logic dly;
    logic ext;
    logic [1:0] fs;
    logic [6:0] sg;
    logic [1:0] rs;
  } ldui_row_t;
  logic clk = 1'b0, rst = 1'b1, btn_up = 1'b0, btn_down = 1'b0;
  logic reset_btn = 1'b0, sw9_on = 1'b0, sw10_on = 1'b0, occ = 1'b0;
  logic delay_active = 1'b0, ext_active = 1'b0, low_supply = 1'b0;
  logic fault_open = 1'b0, fault_short = 1'b0, fault_change = 1'b0;
  logic pwr_fail = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] str = 4'h0, avs_address = 4'h0;
  logic [9:0] loop_freq_khz = 10'h07B; // 123 kHz, three digits
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic vehicle_present, call_in, avs_waitrequest, lamp_power;
  logic lamp_output, lamp_fault, call_a, retune;
  logic [3:0] strength, sens_level;
  logic [6:0] seg;
  logic [1:0] freq_sel;
  int n_fail = 0, checks_done = 0, r, t, w, u;
  // Switch, loop and timing cases with expected indication
  ldui_row_t rows [4] = '{
    '{1'b1, 1'b1, 1'b0, 4'h0, 1'b0, 1'b0, 2'h0, SG[0], 2'h0},
    '{1'b0, 1'b1, 1'b1, 4'hC, 1'b0, 1'b0, 2'h1, SG[9], 2'h0},
    '{1'b1, 1'b0, 1'b0, 4'h0, 1'b1, 1'b0, 2'h2, SG[10], 2'h1},
    '{1'b0, 1'b0, 1'b0, 4'h0, 1'b0, 1'b1, 2'h3, SG[11], 2'h2}};

  ldui_top #(.TICK_CYCLES(TC)) ldui_top_i (.clk, .rst, .btn_up,
    .btn_down, .reset_btn, .sw9_on, .sw10_on, .vehicle_present,
    .call_in, .delay_active, .ext_active, .fault_open, .fault_short,
    .fault_change, .low_supply, .pwr_fail, .strength, .loop_freq_khz,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .lamp_power, .lamp_output, .lamp_fault, .seg,
    .call_a, .freq_sel, .sens_level, .retune);
  ldui_loop_model ldui_loop_model_i (.occupy(occ), .level_set(str),
    .vehicle_present, .call_in, .strength);

  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  initial forever #12.5 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic wms(input int n);
    repeat (n * TC) @(posedge clk);
  endtask

  // One Avalon access; held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  // Rising edges of one lamp and of retune over a span
  task automatic cnt(input int sel, input int ms, output int rl,
                     output int rr);
    logic p, v, pr;
    rl = 0;
    rr = 0;
    p = 1'b1;
    pr = 1'b1;
    repeat (ms * TC) begin
      @(posedge clk);
      v = sel == 0 ? lamp_power : sel == 1 ? lamp_fault : lamp_output;
      if (v === 1'b1 && p !== 1'b1) rl++;
      if (retune === 1'b1 && pr !== 1'b1) rr++;
      p = v;
      pr = retune;
    end
  endtask

  task automatic press(input logic up);
    if (up) btn_up <= 1'b1;
    else btn_down <= 1'b1;
    repeat (3) @(posedge clk);
    btn_up <= 1'b0;
    btn_down <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic stop_test;
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ------------------------------------------------
  // Sequence
  // ------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("power lamp", lamp_power, 1);
    chk("level", sens_level, 4);
    chk("freq_sel", freq_sel, 3);
    bus(1'b0, ldui_pkg::ADDR_STATUS, 32'h0, q);
    chk("mode", q[5], 0);
    wms(250);
    chk("digit 1", seg, SG[1]);
    wms(750);
    chk("digit 2", seg, SG[2]);
    wms(750);
    chk("digit 3", seg, SG[3]);
    wms(550);
    chk("meter idle", seg, SG[0]);
    foreach (rows[i]) begin
      sw9_on <= rows[i].s9;
      sw10_on <= rows[i].s10;
      occ <= rows[i].occ;
      str <= rows[i].str;
      delay_active <= rows[i].dly;
      ext_active <= rows[i].ext;
      wms(20);
      chk("freq_sel", freq_sel, rows[i].fs);
      chk("meter", seg, rows[i].sg);
      cnt(2, 500, r, u);
      chk("output flash", r, rows[i].rs);
    end
    ext_active <= 1'b0;
    press(1'b1);
    chk("first press", sens_level, 4);
    chk("meter level", seg, SG[4]);
    press(1'b1);
    chk("level up", sens_level, 5);
    chk("meter level", seg, SG[5]);
    press(1'b0);
    chk("level down", sens_level, 4);
    occ <= 1'b1;
    press(1'b1);
    chk("occupied press", sens_level, 4);
    occ <= 1'b0;
    bus(1'b1, ldui_pkg::ADDR_CTRL, 32'h9, q);
    press(1'b1);
    chk("level top", sens_level, 9);
    bus(1'b1, ldui_pkg::ADDR_CTRL, 32'hC, q);
    bus(1'b0, ldui_pkg::ADDR_CTRL, 32'h0, q);
    chk("level clamp", q[3:0], 9);
    bus(1'b0, 4'h8, 32'h0, q);
    chk("unmapped", q, 0);
    for (int k = 1; k <= 3; k++) begin
      {fault_change, fault_short, fault_open} <= 3'(1 << (k - 1));
      cnt(1, 500, r, u);
      chk("call a", call_a, 1);
      // F and code ride the free 2 s frame; a 3 s step shifts it by 1 s
      chk("meter F", seg, (k == 2) ? SG[k] : SG[12]);
      cnt(1, 1000, t, u);
      chk("fault code", seg, (k == 2) ? SG[12] : SG[k]);
      cnt(1, 1500, w, u);
      chk("fault flashes", r + t + w, k);
    end
    {fault_change, fault_short, fault_open} <= 3'h0;
    cnt(1, 3000, r, u);
    chk("last fault", r, 3);
    chk("retune", u, 1);
    chk("meter normal", seg, SG[0]);
    chk("output normal", lamp_output, 0);
    bus(1'b0, ldui_pkg::ADDR_STATUS, 32'h0, q);
    chk("fault memory", q[7:6], ldui_pkg::FLT_CHANGE);
    chk("fault now", q[9:8], ldui_pkg::FLT_NONE);
    reset_btn <= 1'b1;
    cnt(1, 200, r, u);
    chk("button retune", u, 1);
    chk("fault cleared", r + lamp_fault, 0);
    reset_btn <= 1'b0;
    // Lamp may be dark by pattern alone; the memory bits prove the clear
    bus(1'b0, ldui_pkg::ADDR_STATUS, 32'h0, q);
    chk("fault memory", q[7:6], ldui_pkg::FLT_NONE);
    // Down press: a window left open would step the level to 8
    press(1'b0);
    chk("window over", sens_level, 9);
    occ <= 1'b1;
    wms(10);
    pwr_fail <= 1'b1;
    wms(3500);
    chk("call held", call_a, 1);
    wms(600);
    chk("call dropped", call_a, 0);
    pwr_fail <= 1'b0;
    occ <= 1'b0;
    low_supply <= 1'b1;
    wms(10);
    cnt(0, 2000, r, u);
    chk("power blink", r, 1);
    chk("dark lamps", {lamp_output, lamp_fault, seg}, 0);
    stop_test;
  end

  // Cut a hang short
  initial begin
    repeat (98000) @(posedge clk);
    n_fail++;
    stop_test;
  end
endmodule // ldui_top_tb

`default_nettype wire
